// [rtl/csd_params.svh]
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

// Opcode and field layout of the instruction word.
`define CSD_OPC_HI        15
`define CSD_OPC_LO        9
`define CSD_ACCESS_BIT    8
`define CSD_FILE_HI       7
`define CSD_FILE_LO       0
`define CSD_OPC_GREATER   7'h32
`define CSD_OPC_LESS      7'h30

// Data address formation.
`define CSD_ADDR_W        12
`define CSD_BANK_W        4
`define CSD_INDEXED_MAX   8'h5F
`define CSD_ACCESS_LOW    4'h0
`define CSD_ACCESS_HIGH   4'hF

// Borrow position of the nine-bit compare difference.
`define CSD_BORROW_BIT    8

// Phase numbering within one instruction cycle.
`define CSD_Q1            2'h0
`define CSD_Q2            2'h1
`define CSD_Q3            2'h2
`define CSD_Q4            2'h3

`endif

// [rtl/csd_pkg.sv]
package csd_pkg;

    typedef enum logic [1:0] {
        CSD_IDLE  = 2'b00,
        CSD_EXEC  = 2'b01,
        CSD_SKIP1 = 2'b10,
        CSD_SKIP2 = 2'b11
    } csd_state_t;

    typedef struct packed {
        csd_state_t  state;
        logic [1:0]  phase;
        logic        greater;
        logic [11:0] addr;
        logic        take_skip;
        logic        two_word;
        logic        ready;
        logic        decode;
        logic        data_rd;
        logic        process;
        logic        nop;
        logic        discard;
        logic        pc_advance;
        logic        skip;
        logic        done;
    } csd_regs_t;

endpackage

// [rtl/csd_decode.sv]
`include "csd_params.svh"

// Behaviour
// - Greater variant is upper byte 0110 010a, less variant 0110 000a.
// - Greater: byte above working register discards next instruction, runs a no-operation.
// - Less: byte below working register discards next instruction; otherwise continue normally.
// - Unsigned subtraction byte minus working register; decides skip only, no flags.
// - Selector 0 uses access bank; selector 1 uses bank select register bank.
// - Selector 0 with extended set and address up to 95 uses indexed offset.
// - One cycle without skip, two when skipping, three over a two-word instruction.
// - Q1 decode, Q2 read, Q3 compare, Q4 no write; skip cycles all no-operation.
module csd_decode (
    // Clock and reset, one edge per phase.
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // Instruction from fetch.
    input  wire logic [15:0] instr_i,
    input  wire logic        instr_valid_i,
    input  wire logic        next_two_word_i,
    // Core state used by the operand path.
    input  wire logic [7:0]  working_register_i,
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic        extended_enable_i,
    input  wire logic [11:0] index_base_i,
    // Data memory read port.
    input  wire logic [7:0]  data_i,
    output logic [11:0]      data_addr_o,
    output logic             data_rd_o,
    // Sequencing outputs.
    output logic             ready_o,
    output logic             decode_o,
    output logic             process_o,
    output logic             nop_o,
    output logic             discard_o,
    output logic             pc_advance_o,
    output logic             skip_o,
    output logic             done_o
);

    csd_pkg::csd_regs_t r;
    csd_pkg::csd_regs_t next_r;

    function automatic logic [1:0] match_opcode(input logic [15:0] ins);
        logic [6:0] opc;
        opc = ins[`CSD_OPC_HI:`CSD_OPC_LO];
        match_opcode = {opc == `CSD_OPC_GREATER, opc == `CSD_OPC_LESS};
    endfunction

    function automatic logic [11:0] operand_addr(input logic [15:0] ins, input logic [3:0] bank,
                                                 input logic ext, input logic [11:0] base);
        logic [7:0] f;
        f = ins[`CSD_FILE_HI:`CSD_FILE_LO];
        if (ins[`CSD_ACCESS_BIT]) begin
            operand_addr = {bank, f};
        end else if (ext && f <= `CSD_INDEXED_MAX) begin
            operand_addr = base + {4'h0, f};
        end else if (f <= `CSD_INDEXED_MAX) begin
            operand_addr = {`CSD_ACCESS_LOW, f};
        end else begin
            operand_addr = {`CSD_ACCESS_HIGH, f};
        end
    endfunction

    always_comb begin
        logic [1:0] hit;
        logic [8:0] diff;
        logic       gt;
        logic       lt;
        hit                = match_opcode(instr_i);
        diff               = {1'b0, data_i} - {1'b0, working_register_i};
        gt                 = !diff[`CSD_BORROW_BIT] && diff[`CSD_BORROW_BIT-1:0] != 8'h00;
        lt                 = diff[`CSD_BORROW_BIT];
        next_r             = r;
        next_r.decode      = 1'b0;
        next_r.data_rd     = 1'b0;
        next_r.process     = 1'b0;
        next_r.discard     = 1'b0;
        next_r.pc_advance  = 1'b0;
        next_r.done        = 1'b0;
        next_r.phase       = r.phase + 2'h1;
        unique case (r.state)
            csd_pkg::CSD_IDLE: begin
                next_r.phase = `CSD_Q1;
                next_r.nop   = 1'b0;
                next_r.skip  = 1'b0;
                if (instr_valid_i && hit != 2'b00) begin
                    next_r.state   = csd_pkg::CSD_EXEC;
                    next_r.greater = hit[1];
                    next_r.addr    = operand_addr(instr_i, bank_select_register_i,
                                                  extended_enable_i, index_base_i);
                    next_r.ready   = 1'b0;
                    next_r.decode  = 1'b1;
                end
            end
            csd_pkg::CSD_EXEC: begin
                unique case (r.phase)
                    `CSD_Q1: begin
                        next_r.data_rd = 1'b1;
                    end
                    `CSD_Q2: begin
                        next_r.process   = 1'b1;
                        next_r.take_skip = r.greater ? gt : lt;
                    end
                    `CSD_Q3: begin
                        next_r.two_word = next_two_word_i;
                    end
                    `CSD_Q4: begin
                        if (r.take_skip) begin
                            next_r.state      = csd_pkg::CSD_SKIP1;
                            next_r.nop        = 1'b1;
                            next_r.skip       = 1'b1;
                            next_r.discard    = 1'b1;
                            next_r.pc_advance = 1'b1;
                        end else begin
                            next_r.state = csd_pkg::CSD_IDLE;
                            next_r.ready = 1'b1;
                            next_r.done  = 1'b1;
                        end
                    end
                endcase
            end
            csd_pkg::CSD_SKIP1: begin
                if (r.phase == `CSD_Q4) begin
                    if (r.two_word) begin
                        next_r.state      = csd_pkg::CSD_SKIP2;
                        next_r.pc_advance = 1'b1;
                    end else begin
                        next_r.state = csd_pkg::CSD_IDLE;
                        next_r.nop   = 1'b0;
                        next_r.skip  = 1'b0;
                        next_r.ready = 1'b1;
                        next_r.done  = 1'b1;
                    end
                end
            end
            csd_pkg::CSD_SKIP2: begin
                if (r.phase == `CSD_Q4) begin
                    next_r.state = csd_pkg::CSD_IDLE;
                    next_r.nop   = 1'b0;
                    next_r.skip  = 1'b0;
                    next_r.ready = 1'b1;
                    next_r.done  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            r       <= '0;
            r.ready <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign data_addr_o  = r.addr;
    assign data_rd_o    = r.data_rd;
    assign ready_o      = r.ready;
    assign decode_o     = r.decode;
    assign process_o    = r.process;
    assign nop_o        = r.nop;
    assign discard_o    = r.discard;
    assign pc_advance_o = r.pc_advance;
    assign skip_o       = r.skip;
    assign done_o       = r.done;

endmodule // csd_decode

// [sim/csd_decode_properties.sv]
module csd_props (
    input wire logic        clock_i, rst_i, ready_o, instr_valid_i, decode_o, data_rd_o, process_o,
    input wire logic        nop_o, skip_o, discard_o, pc_advance_o, done_o,
    input wire logic [15:0] instr_i,
    input wire logic [11:0] data_addr_o,
    input wire logic [7:0]  data_i, working_register_i,
    input wire logic [3:0]  bank_select_register_i
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire take = ready_o && instr_valid_i && instr_i[15:9] inside {7'h32, 7'h30};
    sequence s_exec; data_rd_o ##1 process_o; endsequence
    AST_TAKE: assert property (take |=> decode_o && !ready_o) else $error("take missed");
    AST_REFUSE: assert property (ready_o && instr_valid_i && instr_i[15:9] == 7'h31 |=> ready_o)
        else $error("taken");
    AST_PHASES: assert property (decode_o |=> s_exec) else $error("phase order");
    AST_LEN: assert property (process_o |-> ##2 (done_o ^ discard_o)) else $error("cycle end");
    AST_SKIP: assert property (discard_o |-> nop_o && skip_o && pc_advance_o) else $error("skip start");
    AST_NOP: assert property ($rose(nop_o) |-> nop_o[*4]) else $error("skip short");
    AST_QUIET: assert property (nop_o |-> !(decode_o || data_rd_o || process_o)) else $error("busy in skip");
    AST_EQUAL: assert property (data_rd_o && data_i == working_register_i |-> ##3 !discard_o) else $error("eq");
    AST_BANK: assert property (take && instr_i[8] |=>
        data_addr_o == {$past(bank_select_register_i), $past(instr_i[7:0])}) else $error("bank address");
    AST_PC: assert property (discard_o |-> ##4 (done_o ^ pc_advance_o)) else $error("pc advance");
endmodule // csd_props
bind csd_decode csd_props i_props (.clock_i, .rst_i, .ready_o, .instr_valid_i, .decode_o, .data_rd_o, .process_o,
    .nop_o, .skip_o, .discard_o, .pc_advance_o, .done_o, .instr_i, .data_addr_o, .data_i, .working_register_i,
    .bank_select_register_i);

// [sim/csd_mem_model.sv]
module csd_mem_model (
    input  wire logic [11:0] addr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [4096];
    // Outside a read the bus shows the inverse, so a stale byte is never used.
    assign data_o = rd_i ? mem[addr_i] : ~mem[addr_i];
endmodule // csd_mem_model

// [sim/tb_csd_decode.sv]
module tb_csd_decode;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i = 1'b0, rst_i = 1'b1, vld = 1'b0, two = 1'b0, ext = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [7:0]  w = 8'h00, data;
    logic [11:0] addr;
    logic        rd, ready, dec, pc, done, proc, nop, disc, skp;
    logic [3:0]  bank_select_register = 4'h5;
    int          errors = 0, compares = 0;
    always #20 clock_i = ~clock_i;
    csd_decode i_dut (.clock_i, .rst_i, .instr_i(instr), .instr_valid_i(vld), .next_two_word_i(two),
        .working_register_i(w), .bank_select_register_i(bank_select_register), .extended_enable_i(ext), .index_base_i(12'h100),
        .data_i(data), .data_addr_o(addr), .data_rd_o(rd), .ready_o(ready), .decode_o(dec), .process_o(proc),
        .nop_o(nop), .discard_o(disc), .pc_advance_o(pc), .skip_o(skp), .done_o(done));
    csd_mem_model i_mem (.addr_i(addr), .rd_i(rd), .data_o(data));
    task automatic chk(input logic [11:0] got, exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick;
        @(posedge clock_i);
        #1;
    endtask
    task automatic run(input logic [6:0] op, input logic a, input logic [7:0] f, d);
        logic [11:0] ea;
        logic        sk;
        int          n;
        int          pcs;
        int          nops;
        int          dcs;
        int          prs;
        ea = a ? {bank_select_register, f} : (ext && f <= 8'h5F) ? 12'h100 + 12'(f) : {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
        sk = (op == 7'h32) ? d > w : d < w;
        n = 0;
        pcs = 0;
        nops = 0;
        dcs = 0;
        prs = 0;
        i_mem.mem[ea] = d;
        instr = {op, a, f};
        vld = 1'b1;
        tick;
        vld = 1'b0;
        chk(addr, ea);
        while (done !== 1'b1 && n < 20) begin
            pcs += int'(pc === 1'b1);
            nops += int'(nop === 1'b1 && skp === 1'b1);
            dcs += int'(disc === 1'b1);
            prs += int'(proc === 1'b1);
            tick;
            n++;
        end
        chk(12'(nops), sk ? (two ? 12'h008 : 12'h004) : 12'h000);
        chk(12'(dcs), sk ? 12'h001 : 12'h000);
        chk(12'(prs), 12'h001);
        chk(12'(n), sk ? (two ? 12'h00C : 12'h008) : 12'h004);
        chk(12'(pcs), sk ? (two ? 12'h002 : 12'h001) : 12'h000);
    endtask
    task automatic t_greater;
        w = 8'h80;
        run(7'h32, 1'b1, 8'h10, 8'h81);
        run(7'h32, 1'b1, 8'h11, 8'h80);
        run(7'h32, 1'b1, 8'h12, 8'h7F);
        $display("test greater done");
    endtask
    task automatic t_less;
        w = 8'h01;
        run(7'h30, 1'b1, 8'h20, 8'h00);
        run(7'h30, 1'b1, 8'h21, 8'h01);
        run(7'h30, 1'b1, 8'h22, 8'hFF);
        $display("test less done");
    endtask
    task automatic t_two;
        two = 1'b1;
        run(7'h32, 1'b1, 8'h30, 8'hFF);
        run(7'h30, 1'b1, 8'h31, 8'h00);
        run(7'h30, 1'b1, 8'h32, 8'h40);
        two = 1'b0;
        $display("test two word done");
    endtask
    task automatic t_addr;
        ext = 1'b1;
        run(7'h32, 1'b0, 8'h5F, 8'h00);
        run(7'h32, 1'b0, 8'h60, 8'h02);
        ext = 1'b0;
        run(7'h30, 1'b0, 8'hA0, 8'h00);
        run(7'h32, 1'b0, 8'h10, 8'h05);
        bank_select_register = 4'hA;
        run(7'h30, 1'b1, 8'h33, 8'h00);
        $display("test address done");
    endtask
    task automatic t_reset;
        w = 8'h01;
        i_mem.mem[{bank_select_register, 8'h40}] = 8'h00;
        instr = {7'h30, 1'b1, 8'h40};
        vld = 1'b1;
        tick;
        vld = 1'b0;
        repeat (5) tick;
        chk(12'(nop), 12'h001);
        rst_i = 1'b1;
        tick;
        rst_i = 1'b0;
        chk(12'({ready, nop, dec, done}), 12'h008);
        chk(addr, 12'h000);
        run(7'h30, 1'b1, 8'h41, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_refuse;
        instr = {7'h31, 1'b1, 8'h00};
        vld = 1'b1;
        repeat (8) begin
            tick;
            chk(12'({dec, ready}), 12'h001);
        end
        vld = 1'b0;
        $display("test refuse done");
    endtask
    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        #1 rst_i = 1'b0;
        chk(12'(ready), 12'h001);
        t_greater;
        t_less;
        t_two;
        t_reset;
        t_addr;
        t_refuse;
        conclude;
    end
    // The tests need well under a thousand cycles.
    initial begin
        #200000;
        errors++;
        conclude;
    end
endmodule // tb_csd_decode
